// >>> hw/pse_mode_pkg.sv
package pse_mode_pkg;

    // ==========================================================
    // Channel count and register offsets
    localparam int NUM_CH = 4;
    localparam logic [7:0] ADDR_PWR_EVENT = 8'h02;
    localparam logic [7:0] ADDR_FAULT_EVENT = 8'h06;
    localparam logic [7:0] ADDR_PWR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h12;
    localparam logic [7:0] ADDR_DISC_EN = 8'h13;
    localparam logic [7:0] ADDR_DET_CLS_EN = 8'h14;
    localparam logic [7:0] ADDR_PRIO_CUT = 8'h15;
    localparam logic [7:0] ADDR_RESTART = 8'h18;
    localparam logic [7:0] ADDR_PWR_ENABLE = 8'h19;
    localparam logic [7:0] ADDR_POLICE_FIRST = 8'h1e;
    localparam logic [7:0] ADDR_POLICE_LAST = 8'h21;
    localparam logic [7:0] ADDR_FOLDBACK = 8'h40;

    // ==========================================================
    // Field positions and reset values
    localparam int MODE_W = 2;
    localparam int CLASS_LSB = 4;
    localparam int DETECT_LSB = 0;
    localparam int PWR_OFF_LSB = 4;
    localparam int PWR_ON_LSB = 0;
    localparam logic [1:0] POLICE_IDX_OFS = 2'h2;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_DISC_EN = 8'h0f;
    localparam logic [7:0] RST_PRIO_CUT = 8'h00;
    localparam logic [7:0] POLICE_CLEARED = 8'hff;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_FREQ_KHZ = 200000;
    localparam int unsigned ABOVE_HOLD_MS = 3;
    localparam int unsigned ABOVE_HOLD_CYCLES = ABOVE_HOLD_MS * CLK_FREQ_KHZ;
    localparam int unsigned DISC_TIMEOUT_MS = 300;
    localparam int unsigned DISC_TIMEOUT_CYCLES = DISC_TIMEOUT_MS * CLK_FREQ_KHZ;
    localparam int unsigned COOLDOWN_MS = 1000;
    localparam int unsigned COOLDOWN_CYCLES = COOLDOWN_MS * CLK_FREQ_KHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_MANUAL = 2'h1,
        MODE_SEMI = 2'h2,
        MODE_AUTO = 2'h3
    } chan_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [NUM_CH-1:0] det_done;
        logic [NUM_CH-1:0] det_valid;
        logic [NUM_CH-1:0] cls_done;
        logic [NUM_CH-1:0] cls_valid;
    } meas_t;

endpackage

// >>> hw/pse_channel_mode_control.sv
`timescale 1ns/1ps
module pse_channel_mode_control #(
    parameter int unsigned ABOVE_HOLD_CYCLES = pse_mode_pkg::ABOVE_HOLD_CYCLES,
    parameter int unsigned DISC_TIMEOUT_CYCLES = pse_mode_pkg::DISC_TIMEOUT_CYCLES,
    parameter int unsigned COOLDOWN_CYCLES = pse_mode_pkg::COOLDOWN_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire pse_mode_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire pse_mode_pkg::meas_t meas_in,
    input wire logic [pse_mode_pkg::NUM_CH-1:0] current_above_in,
    input wire logic [pse_mode_pkg::NUM_CH-1:0] power_good_in,
    input wire logic [pse_mode_pkg::NUM_CH-1:0] cooldown_start_in,
    input wire logic [pse_mode_pkg::NUM_CH*8-1:0] police_load_in,
    input wire logic [pse_mode_pkg::NUM_CH-1:0] foldback_load_in,
    output logic [pse_mode_pkg::NUM_CH-1:0] run_detect_out,
    output logic [pse_mode_pkg::NUM_CH-1:0] run_class_out,
    output logic [pse_mode_pkg::NUM_CH-1:0] power_enable_out,
    output logic [pse_mode_pkg::NUM_CH-1:0] cooldown_active_out,
    output logic [pse_mode_pkg::NUM_CH*8-1:0] police_out,
    output logic [pse_mode_pkg::NUM_CH-1:0] foldback_out,
    output logic [7:0] fast_shutdown_cut_out
);

    localparam int N = pse_mode_pkg::NUM_CH;

    // ==========================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // ==========================================================
    // Register decode
    wire wr_mode = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_MODE;
    wire wr_disc = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_DISC_EN;
    wire wr_en = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_DET_CLS_EN;
    wire wr_prio = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_PRIO_CUT;
    wire wr_restart = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_RESTART;
    wire wr_pwr = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_PWR_ENABLE;
    wire wr_pevt = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_PWR_EVENT;
    wire wr_fevt = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_FAULT_EVENT;
    wire wr_fb = reg_req_in.wr && reg_req_in.addr == pse_mode_pkg::ADDR_FOLDBACK;
    wire hit_police = reg_req_in.addr >= pse_mode_pkg::ADDR_POLICE_FIRST &&
                      reg_req_in.addr <= pse_mode_pkg::ADDR_POLICE_LAST;
    wire [1:0] police_idx = reg_req_in.addr[1:0] + pse_mode_pkg::POLICE_IDX_OFS;

    // ==========================================================
    // Shared registers
    logic [7:0] mode_ff, disc_en_ff, prio_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= pse_mode_pkg::RST_MODE;
            disc_en_ff <= pse_mode_pkg::RST_DISC_EN;
            prio_ff <= pse_mode_pkg::RST_PRIO_CUT;
        end else begin
            if (wr_mode) begin
                mode_ff <= reg_req_in.wdata;
            end
            if (wr_disc) begin
                disc_en_ff <= reg_req_in.wdata;
            end
            if (wr_prio) begin
                prio_ff <= reg_req_in.wdata;
            end
        end
    end

    assign fast_shutdown_cut_out = prio_ff;

    // ==========================================================
    // Per-channel control
    logic [N-1:0] de_v, ce_v, pg_v, pgc_v, pec_v, disf_v;

    // Each channel keeps its own state and timers.
    for (genvar i = 0; i < N; i++) begin : g_ch
        logic de_ff, ce_ff, pwr_ff, pg_ff, pgc_ff, pec_ff, disf_ff, fb_ff, det_ok_ff;
        logic [7:0] police_ff;
        logic [31:0] cool_ff, disc_ff, above_cnt_ff;
        logic [2:0] above_sync_ff, pg_sync_ff;
        logic above_ff, pg_pin_ff, nxt_de, nxt_ce, nxt_pwr;

        wire [1:0] mode_now = mode_ff[i*pse_mode_pkg::MODE_W +: pse_mode_pkg::MODE_W];
        wire [1:0] mode_new = reg_req_in.wdata[i*pse_mode_pkg::MODE_W +: pse_mode_pkg::MODE_W];
        wire is_off = mode_now == pse_mode_pkg::MODE_OFF;
        wire is_manual = mode_now == pse_mode_pkg::MODE_MANUAL;
        wire is_semi = mode_now == pse_mode_pkg::MODE_SEMI;
        wire is_auto = mode_now == pse_mode_pkg::MODE_AUTO;
        wire going_off = wr_mode && mode_new == pse_mode_pkg::MODE_OFF && !is_off;
        wire leave_semi = wr_mode && is_semi &&
                          (mode_new == pse_mode_pkg::MODE_OFF || mode_new == pse_mode_pkg::MODE_MANUAL);
        wire cooling = cool_ff != 32'h0;
        wire en_wr_det = wr_en && reg_req_in.wdata[pse_mode_pkg::DETECT_LSB + i];
        wire en_wr_cls = wr_en && reg_req_in.wdata[pse_mode_pkg::CLASS_LSB + i];
        wire rs_det = wr_restart && !is_off && reg_req_in.wdata[pse_mode_pkg::DETECT_LSB + i];
        wire rs_cls = wr_restart && !is_off && reg_req_in.wdata[pse_mode_pkg::CLASS_LSB + i];
        wire pwr_on_cmd = wr_pwr && !is_off && reg_req_in.wdata[pse_mode_pkg::PWR_ON_LSB + i];
        wire pwr_off_cmd = wr_pwr && reg_req_in.wdata[pse_mode_pkg::PWR_OFF_LSB + i];
        wire idle_ok = !is_off && !pwr_ff && !cooling;
        wire run_det = idle_ok && de_ff && (!is_auto || ce_ff);
        wire run_cls = idle_ok && ce_ff && (is_manual ? !de_ff : de_ff && det_ok_ff);
        wire det_end = run_det && meas_in.det_done[i];
        wire cls_end = run_cls && meas_in.cls_done[i];
        wire auto_grant = is_auto && cls_end && meas_in.cls_valid[i];
        wire above_held = above_ff && above_cnt_ff == 32'(ABOVE_HOLD_CYCLES - 1);
        wire disc_armed = pwr_ff && disc_en_ff[i];
        wire disc_timeout = disc_armed && !above_ff && disc_ff == 32'(DISC_TIMEOUT_CYCLES - 1);
        wire pwr_rise = nxt_pwr && !pwr_ff;
        wire wr_my_police = reg_req_in.wr && hit_police && police_idx == 2'(i);

        // A register write outranks the completion clear, so a new request is never lost.
        always_comb begin
            nxt_de = de_ff;
            nxt_ce = ce_ff;
            if (going_off || (is_manual && pwr_off_cmd)) begin
                nxt_de = 1'b0;
                nxt_ce = 1'b0;
            end else begin
                if (en_wr_det || rs_det) begin
                    nxt_de = 1'b1;
                end else if (wr_en) begin
                    nxt_de = 1'b0;
                end else if (is_manual && det_end) begin
                    nxt_de = 1'b0;
                end
                if (en_wr_cls || rs_cls) begin
                    nxt_ce = 1'b1;
                end else if (wr_en) begin
                    nxt_ce = 1'b0;
                end else if (is_manual && cls_end) begin
                    nxt_ce = 1'b0;
                end
            end
        end

        always_comb begin
            nxt_pwr = pwr_ff;
            if (going_off || disc_timeout || pwr_off_cmd) begin
                nxt_pwr = 1'b0;
            end else if (pwr_on_cmd || auto_grant) begin
                nxt_pwr = 1'b1;
            end
        end

        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                above_sync_ff <= 3'h0;
                above_ff <= 1'b0;
                pg_sync_ff <= 3'h0;
                pg_pin_ff <= 1'b0;
            end else begin
                above_sync_ff <= {above_sync_ff[1:0], current_above_in[i]};
                pg_sync_ff <= {pg_sync_ff[1:0], power_good_in[i]};
                if (above_sync_ff[2] == above_sync_ff[1]) begin
                    above_ff <= above_sync_ff[2];
                end
                if (pg_sync_ff[2] == pg_sync_ff[1]) begin
                    pg_pin_ff <= pg_sync_ff[2];
                end
            end
        end

        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                de_ff <= 1'b0;
                ce_ff <= 1'b0;
                pwr_ff <= 1'b0;
                pg_ff <= 1'b0;
                det_ok_ff <= 1'b0;
            end else begin
                de_ff <= nxt_de;
                ce_ff <= nxt_ce;
                pwr_ff <= nxt_pwr;
                pg_ff <= nxt_pwr && pg_pin_ff;
                det_ok_ff <= (going_off || nxt_pwr || cls_end) ? 1'b0 :
                             det_end ? meas_in.det_valid[i] : det_ok_ff;
            end
        end

        // Event bits: a new set wins over a write-one clear in the same cycle.
        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                pgc_ff <= 1'b0;
                pec_ff <= 1'b0;
                disf_ff <= 1'b0;
            end else begin
                pgc_ff <= (pg_ff && !(nxt_pwr && pg_pin_ff)) ||
                          (pgc_ff && !(wr_pevt && reg_req_in.wdata[4 + i]));
                pec_ff <= (pwr_ff && !nxt_pwr) || (pec_ff && !(wr_pevt && reg_req_in.wdata[i]));
                disf_ff <= disc_timeout ||
                           (disf_ff && !going_off && !(wr_fevt && reg_req_in.wdata[i]));
            end
        end

        // Manual power-on takes no class values; software programs them.
        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                police_ff <= pse_mode_pkg::POLICE_CLEARED;
                fb_ff <= 1'b0;
            end else if (going_off) begin
                police_ff <= pse_mode_pkg::POLICE_CLEARED;
                fb_ff <= 1'b0;
            end else if (pwr_rise && !is_manual) begin
                police_ff <= police_load_in[i*8 +: 8];
                fb_ff <= foldback_load_in[i];
            end else begin
                if (wr_my_police) begin
                    police_ff <= reg_req_in.wdata;
                end
                if (wr_fb) begin
                    fb_ff <= reg_req_in.wdata[i];
                end
            end
        end

        // The cooldown only blocks new cycles; switching to off from manual or auto keeps it running.
        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                cool_ff <= 32'h0;
            end else if (leave_semi) begin
                cool_ff <= 32'h0;
            end else if (cooldown_start_in[i]) begin
                cool_ff <= 32'(COOLDOWN_CYCLES);
            end else if (cooling) begin
                cool_ff <= cool_ff - 32'h1;
            end
        end

        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                above_cnt_ff <= 32'h0;
                disc_ff <= 32'h0;
            end else begin
                above_cnt_ff <= !(above_ff && pwr_ff) ? 32'h0 :
                                above_held ? above_cnt_ff : above_cnt_ff + 32'h1;
                if (!disc_armed || above_held || disc_timeout) begin
                    disc_ff <= 32'h0;
                end else if (!above_ff) begin
                    disc_ff <= disc_ff + 32'h1;
                end
            end
        end

        assign run_detect_out[i] = run_det;
        assign run_class_out[i] = run_cls;
        assign power_enable_out[i] = pwr_ff;
        assign cooldown_active_out[i] = cooling;
        assign police_out[i*8 +: 8] = police_ff;
        assign foldback_out[i] = fb_ff;
        assign de_v[i] = de_ff;
        assign ce_v[i] = ce_ff;
        assign pg_v[i] = pg_ff;
        assign pgc_v[i] = pgc_ff;
        assign pec_v[i] = pec_ff;
        assign disf_v[i] = disf_ff;

        // ======================================================
        // Checks
        sequence s_off_request;
            going_off && !wr_en;
        endsequence
        sequence s_off_done;
            !de_ff && !ce_ff && !pwr_ff && police_ff == pse_mode_pkg::POLICE_CLEARED && !fb_ff;
        endsequence
        property p_off_clear;
            @(posedge clk_sys_in) disable iff (!rst_n) s_off_request |=> s_off_done;
        endproperty
        a_off_clear: assert property (p_off_clear) else $error("off mode left bits set");

        property p_off_idle;
            @(posedge clk_sys_in) disable iff (!rst_n) is_off |-> !run_detect_out[i] && !run_class_out[i];
        endproperty
        a_off_idle: assert property (p_off_idle) else $error("off channel runs a cycle");

        property p_pec_event;
            @(posedge clk_sys_in) disable iff (!rst_n) $fell(power_enable_out[i]) |-> pec_ff;
        endproperty
        a_pec_event: assert property (p_pec_event) else $error("power enable fall not flagged");

        property p_cool_cancel;
            @(posedge clk_sys_in) disable iff (!rst_n) leave_semi |=> !cooldown_active_out[i];
        endproperty
        a_cool_cancel: assert property (p_cool_cancel) else $error("cooldown survived mode change");

        property p_manual_once;
            @(posedge clk_sys_in) disable iff (!rst_n)
                is_manual && det_end && !wr_en && !rs_det |=> !de_ff ##1 !run_detect_out[i];
        endproperty
        a_manual_once: assert property (p_manual_once) else $error("manual detect repeated");

        property p_power_on;
            @(posedge clk_sys_in) disable iff (!rst_n)
                pwr_on_cmd && !pwr_off_cmd && !going_off |=> power_enable_out[i];
        endproperty
        a_power_on: assert property (p_power_on) else $error("power-on command ignored");

        property p_semi_stop;
            @(posedge clk_sys_in) disable iff (!rst_n)
                (is_semi || is_auto) && run_class_out[i] |-> de_ff && det_ok_ff && !power_enable_out[i];
        endproperty
        a_semi_stop: assert property (p_semi_stop) else $error("class without valid detect");

        sequence s_timeout;
            disc_timeout;
        endsequence
        property p_disc_off;
            @(posedge clk_sys_in) disable iff (!rst_n)
                s_timeout |=> !power_enable_out[i] && disf_ff ##1 disc_ff == 32'h0;
        endproperty
        a_disc_off: assert property (p_disc_off) else $error("disconnect timeout not handled");

        property p_cool_defer;
            @(posedge clk_sys_in) disable iff (!rst_n)
                cooldown_active_out[i] |-> !run_detect_out[i] && !run_class_out[i];
        endproperty
        a_cool_defer: assert property (p_cool_defer) else $error("cycle ran in cooldown");
    end

    // ==========================================================
    // Read path
    logic [7:0] rd_mux;
    logic [7:0] rdata_ff;
    logic rvalid_ff;

    wire [7:0] police_sel = police_out[police_idx*8 +: 8];

    assign rd_mux = (reg_req_in.addr == pse_mode_pkg::ADDR_PWR_EVENT) ? {pgc_v, pec_v} :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_FAULT_EVENT) ? {4'h0, disf_v} :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_PWR_STATUS) ? {pg_v, power_enable_out} :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_MODE) ? mode_ff :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_DISC_EN) ? disc_en_ff :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_DET_CLS_EN) ? {ce_v, de_v} :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_PRIO_CUT) ? prio_ff :
                    (reg_req_in.addr == pse_mode_pkg::ADDR_FOLDBACK) ? {4'h0, foldback_out} :
                    hit_police ? police_sel : 8'h00;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_rvalid_out = rvalid_ff;

    property p_others_kept;
        @(posedge clk_sys_in) disable iff (!rst_n)
            wr_mode && reg_req_in.wdata[7:2] == mode_ff[7:2] && mode_ff[7:2] != 6'h00 && !wr_en
            |=> de_v[3:1] == $past(de_v[3:1]) || $past(meas_in.det_done[3:1]) != 3'h0;
    endproperty
    a_others_kept: assert property (p_others_kept) else $error("other channel disturbed");

    property p_disc_reset_val;
        @(posedge clk_sys_in) $rose(rst_n) |-> disc_en_ff == 8'h0f && mode_ff == 8'h00;
    endproperty
    a_disc_reset_val: assert property (p_disc_reset_val) else $error("bad reset values");

endmodule

// >>> testbench/det_engine_model.sv
`timescale 1ns/1ps
module det_engine_model #(
    parameter int BASE = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] run_detect_in,
    input wire logic [3:0] run_class_in,
    output pse_mode_pkg::meas_t meas_out
);
    // ==========================================================
    // Engine timing
    // Each channel answers after its own delay, so prompt and slow replies both occur.
    logic [3:0] cnt_ff [4];
    logic [3:0] hit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hit[i] = (cnt_ff[i] == 4'(BASE + 3 * i));
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n_in || hit[i] || !(run_detect_in[i] | run_class_in[i])) begin
                cnt_ff[i] <= 4'h0;
            end else begin
                cnt_ff[i] <= cnt_ff[i] + 4'h1;
            end
        end
    end
    assign meas_out.det_done = run_detect_in & hit;
    assign meas_out.det_valid = run_detect_in & hit;
    assign meas_out.cls_done = run_class_in & hit;
    assign meas_out.cls_valid = run_class_in & hit;
endmodule

// >>> testbench/pse_channel_mode_control_tb.sv
`timescale 1ns/1ps
module pse_channel_mode_control_tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    pse_mode_pkg::reg_req_t req = '0;
    pse_mode_pkg::meas_t meas;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] run_det, run_cls, pwr_en;
    logic [31:0] seed = 32'hc85d939f;
    logic [31:0] police = 32'h0;
    logic [3:0] fold = 4'h0;
    logic [3:0] above = 4'h0;
    logic [3:0] cool_start = 4'h0;
    logic [3:0] cool, fb;
    logic [31:0] pol;
    logic [7:0] fsc;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int samples_checked = 0;
    int n;
    always #2.5 clk_sys_in = ~clk_sys_in;
    pse_channel_mode_control #(.ABOVE_HOLD_CYCLES(8), .DISC_TIMEOUT_CYCLES(20), .COOLDOWN_CYCLES(10)) uut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .meas_in(meas), .current_above_in(above), .power_good_in(4'hf),
        .cooldown_start_in(cool_start), .police_load_in(police), .foldback_load_in(fold),
        .run_detect_out(run_det), .run_class_out(run_cls), .power_enable_out(pwr_en),
        .cooldown_active_out(cool), .police_out(pol), .foldback_out(fb), .fast_shutdown_cut_out(fsc));
    det_engine_model #(.BASE(2)) engine (.clk_in(clk_sys_in), .rst_n_in(rst_n_in),
        .run_detect_in(run_det), .run_class_in(run_cls), .meas_out(meas));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic end_of_test();
        $display("Compared %0d values, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_sys_in);
        req.wr = 1'b0;
    endtask
    // The expected value is queued before the request so the monitor never races it.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys_in);
        exp_q.push_back(e);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_sys_in);
        req.rd = 1'b0;
    endtask
    task automatic timed_out(input int cnt, input int lim);
        if (cnt >= lim) begin
            chk("wait bound", 8'h00, 8'h01);
            end_of_test();
        end
    endtask
    always @(posedge clk_sys_in) begin
        if (rvalid === 1'b1) begin
            chk("read data", exp_q.pop_front(), rdata);
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        seed = xs(seed);
        police = seed;
        fold = seed[3:0];
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h0f);
        rd(8'h14, 8'h00);
        rd(8'h15, 8'h00);
        rd(8'h7f, 8'h00);
        seed = xs(seed);
        wr(8'h15, seed[7:0]);
        chk("shutdown select", seed[7:0], fsc);
        rd(8'h15, seed[7:0]);
        wr(8'h13, {seed[15:12], 4'h4});
        rd(8'h13, {seed[15:12], 4'h4});
        wr(8'h12, 8'h16);
        rd(8'h12, 8'h16);
        wr(8'h14, 8'h11);
        for (n = 0; run_cls[0] !== 1'b1 && n < 50; n++) @(negedge clk_sys_in);
        timed_out(n, 50);
        chk("idle channels", 8'h00, {2'h0, run_det[3:1], run_cls[3:1]});
        wr(8'h19, 8'h06);
        chk("power on", 8'h06, {4'h0, pwr_en});
        wr(8'h12, 8'h12);
        chk("channel off", 8'h04, {4'h0, pwr_en});
        rd(8'h02, 8'h22);
        rd(8'h14, 8'h11);
        for (n = 0; pwr_en[2] !== 1'b0 && n < 100; n++) @(negedge clk_sys_in);
        timed_out(n, 100);
        chk("disconnect off", 8'h00, {4'h0, pwr_en});
        rd(8'h06, 8'h04);
        rd(8'h02, 8'h66);
        // ==========================================================
        // Cooldown defers cycles on channel 1, then leaving semi-auto cancels it.
        cool_start = 4'h1;
        @(negedge clk_sys_in);
        cool_start = 4'h0;
        chk("cooldown hold", 8'h10, {3'h0, cool[0], 3'h0, run_det[0]});
        for (n = 0; cool[0] !== 1'b0 && n < 20; n++) @(negedge clk_sys_in);
        timed_out(n, 20);
        chk("cycle after cooldown", 8'h01, {7'h0, run_det[0]});
        cool_start = 4'h1;
        @(negedge clk_sys_in);
        cool_start = 4'h0;
        wr(8'h12, 8'h10);
        chk("cooldown cancel", 8'h00, {4'h0, cool});
        rd(8'h14, 8'h00);
        // ==========================================================
        // Manual channel 3 runs one detection; a turn-off command clears its enables.
        wr(8'h14, 8'h04);
        chk("manual start", 8'h04, {4'h0, run_det});
        for (n = 0; run_det[2] !== 1'b0 && n < 30; n++) @(negedge clk_sys_in);
        timed_out(n, 30);
        rd(8'h14, 8'h00);
        chk("manual idle", 8'h00, {run_det, run_cls});
        wr(8'h14, 8'h44);
        wr(8'h19, 8'h40);
        rd(8'h14, 8'h00);
        // ==========================================================
        // Manual power-on keeps software policing; a long high current restarts the timer.
        wr(8'h20, 8'h5a);
        wr(8'h19, 8'h04);
        chk("manual policing", 8'h5a, pol[23:16]);
        rd(8'h20, 8'h5a);
        repeat (8) @(negedge clk_sys_in);
        above = 4'h4;
        repeat (16) @(negedge clk_sys_in);
        above = 4'h0;
        repeat (14) @(negedge clk_sys_in);
        chk("timer restarted", 8'h04, {4'h0, pwr_en});
        for (n = 0; pwr_en[2] !== 1'b0 && n < 40; n++) @(negedge clk_sys_in);
        timed_out(n, 40);
        // ==========================================================
        // Automatic channel 4 is configured first, then powers a valid signature.
        wr(8'h12, 8'hd0);
        wr(8'h18, 8'h88);
        for (n = 0; pwr_en[3] !== 1'b1 && n < 60; n++) @(negedge clk_sys_in);
        timed_out(n, 60);
        chk("auto policing", police[31:24], pol[31:24]);
        chk("auto foldback", {7'h0, fold[3]}, {7'h0, fb[3]});
        rd(8'h10, 8'h88);
        wr(8'h40, 8'h03);
        rd(8'h40, 8'h03);
        repeat (4) @(negedge clk_sys_in);
        end_of_test();
    end
endmodule
